// ### pio_pkg.sv
// package: port block register map, reset values and behaviour list
// Behaviour
// RQ1 - seven bidirectional 8-bit ports, latch driver buffer
// RQ2 - each port read/written through its register
// RQ3 - port zero multiplexes low address and data
// RQ4 - port two drives high address on wide access
// RQ5 - ports seven and eight read pin levels
// RQ6 - four-bit channel select in converter control one
// RQ7 - writes to input-only ports are ignored
// RQ8 - input-only ports byte read, sampled together
// RQ9 - software masks bits used for analog input
// RQ10 - upper four bits of port eight read zero
package pio_pkg;
  localparam int unsigned NUM_PORTS = 7;           // bidirectional ports
  localparam logic [7:0] PORT_ZERO_OFS  = 8'h80;   // register offsets
  localparam logic [7:0] PORT_ONE_OFS   = 8'h90;
  localparam logic [7:0] PORT_TWO_OFS   = 8'ha0;
  localparam logic [7:0] PORT_THREE_OFS = 8'hb0;
  localparam logic [7:0] PORT_FOUR_OFS  = 8'he8;
  localparam logic [7:0] PORT_FIVE_OFS  = 8'hf8;
  localparam logic [7:0] PORT_SIX_OFS   = 8'hfa;
  localparam logic [7:0] PORT_SEVEN_OFS = 8'hdb;
  localparam logic [7:0] CONV_CTRL1_OFS = 8'hdc;
  localparam logic [7:0] PORT_EIGHT_OFS = 8'hdd;
  localparam logic [7:0] LATCH_RESET    = 8'hff;   // port latch reset
  localparam logic [7:0] CONV_CTRL1_RST = 8'h00;   // converter ctrl reset
  localparam logic [7:0] CONV_CTRL1_MSK = 8'h8f;   // implemented bits
  localparam int unsigned CHSEL_MSB = 3;           // channel select field
  localparam int unsigned CHSEL_LSB = 0;
  localparam logic [7:0] ADDR_ZERO_IDX = 8'h00;    // port index of zero
  typedef logic [7:0] pio_byte_t;
endpackage : pio_pkg

// ### pio_ext_if.sv
// interface: external memory bus request between top and pin driver
`timescale 1ns/100ps
interface pio_ext_if;
  logic       addr_phase; // port zero shows low address
  logic       data_out;   // port zero drives write data
  logic       wide_addr;  // port two shows high address
  logic [7:0] addr_lo;    // low address byte
  logic [7:0] addr_hi;    // high address byte
  logic [7:0] wdata;      // write data byte
  modport ctrl (output addr_phase, data_out, wide_addr, addr_lo, addr_hi,
                output wdata);
  modport drv  (input addr_phase, data_out, wide_addr, addr_lo, addr_hi,
                input wdata);
endinterface : pio_ext_if

// ### pio_pin_drv.sv
// module: pin output mux for ports zero and two
`timescale 1ns/100ps
module pio_pin_drv
  import pio_pkg::*;
(
  input  wire logic [7:0] latch_zero, // port zero latch
  input  wire logic [7:0] latch_two,  // port two latch
  pio_ext_if.drv          ext,        // external bus request
  output logic      [7:0] next_zero_o,  // port zero pin value
  output logic            next_zero_oe, // port zero enable
  output logic      [7:0] next_two_o    // port two pin value
);
  // port zero: address, then data, else latch
  always_comb begin
    if (ext.addr_phase) begin
      next_zero_o  = ext.addr_lo; // [RQ3]
      next_zero_oe = 1'b1;
    end else if (ext.data_out) begin
      next_zero_o  = ext.wdata; // [RQ3]
      next_zero_oe = 1'b1;
    end else begin
      next_zero_o  = latch_zero;
      next_zero_oe = 1'b1;
    end
  end
  // port two: high address on wide access, else latch
  always_comb begin
    next_two_o = ext.wide_addr ? ext.addr_hi : latch_two; // [RQ4]
  end
endmodule : pio_pin_drv

// ### pio_ports.sv
// module: parallel and analog input port block
`timescale 1ns/100ps
module pio_ports
  import pio_pkg::*;
(
  input  wire logic       mclk,        // system clock
  input  wire logic       rst_n,       // async reset, active low
  input  wire logic [7:0] reg_addr,    // register address
  input  wire logic       reg_wr,      // register write strobe
  input  wire logic       reg_rd,      // register read strobe
  input  wire logic [7:0] reg_wdata,   // write data
  output logic      [7:0] reg_rdata,   // read data, registered
  input  wire logic       ext_addr,    // memory access address phase
  input  wire logic       ext_write,   // memory write data phase
  input  wire logic       ext_read,    // memory read capture strobe
  input  wire logic       ext_wide,    // 16-bit wide address
  input  wire logic [15:0] ext_a,      // memory address
  input  wire logic [7:0] ext_wd,      // memory write data
  output logic      [7:0] ext_rdata,   // byte read through port zero
  input  wire logic [55:0] port_i,     // bidirectional pin levels
  output logic      [55:0] port_o,     // bidirectional pin values
  output logic      [55:0] port_oe,    // high while driven
  input  wire logic [7:0] ain_seven_i, // port seven pins
  input  wire logic [3:0] ain_eight_i, // port eight pins
  output logic      [3:0] chan_sel     // converter channel select
);
  //////////////////////////////////////////////////////////////////////
  // storage
  pio_byte_t       latch [NUM_PORTS];  // port latches
  logic [55:0]     pin_s1;             // sync stage one
  logic [55:0]     pin_s2;             // sync stage two
  logic [7:0]      sev_s1;             // port seven stage one
  logic [7:0]      sev_s2;             // port seven stage two
  logic [3:0]      eig_s1;             // port eight stage one
  logic [3:0]      eig_s2;             // port eight stage two
  logic [7:0]      conv_ctrl1;         // converter control one
  logic [7:0]      next_zero_o;        // port zero mux value
  logic            next_zero_oe;       // port zero enable
  logic [7:0]      next_two_o;         // port two mux value
  logic [7:0]      next_rdata;         // read mux
  logic [2:0]      wr_idx;             // decoded write port
  logic            wr_hit;             // write hits a latch
  pio_ext_if       ext ();             // bus request bundle

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers, two flops before any use
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      sev_s1 <= '0;
      sev_s2 <= '0;
      eig_s1 <= '0;
      eig_s2 <= '0;
    end else begin
      pin_s1 <= port_i;
      pin_s2 <= pin_s1;
      sev_s1 <= ain_seven_i;
      sev_s2 <= sev_s1; // [RQ5]
      eig_s1 <= ain_eight_i;
      eig_s2 <= eig_s1; // [RQ5]
    end
  end

  //////////////////////////////////////////////////////////////////////
  // write decode to port index
  always_comb begin
    wr_hit = 1'b1;
    wr_idx = 3'd0;
    unique case (reg_addr)
      PORT_ZERO_OFS:  wr_idx = 3'd0;
      PORT_ONE_OFS:   wr_idx = 3'd1;
      PORT_TWO_OFS:   wr_idx = 3'd2;
      PORT_THREE_OFS: wr_idx = 3'd3;
      PORT_FOUR_OFS:  wr_idx = 3'd4;
      PORT_FIVE_OFS:  wr_idx = 3'd5;
      PORT_SIX_OFS:   wr_idx = 3'd6;
      default:        wr_hit = 1'b0; // input ports fall here [RQ7]
    endcase
  end

  // one latch per port, written by software
  generate
    for (genvar g = 0; g < NUM_PORTS; g++) begin : g_latch
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          latch[g] <= LATCH_RESET;
        end else if (reg_wr && wr_hit && wr_idx == 3'(g)) begin
          latch[g] <= reg_wdata; // [RQ2] [RQ1]
        end
      end
    end
  endgenerate

  // converter control one, reserved bits stay zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      conv_ctrl1 <= CONV_CTRL1_RST;
    end else if (reg_wr && reg_addr == CONV_CTRL1_OFS) begin
      conv_ctrl1 <= reg_wdata & CONV_CTRL1_MSK;
    end
  end

  // channel select output
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      chan_sel <= '0;
    end else begin
      chan_sel <= conv_ctrl1[CHSEL_MSB:CHSEL_LSB]; // [RQ6]
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read mux: bidir ports return pin value
  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_addr)
      PORT_ZERO_OFS:  next_rdata = pin_s2[7:0]; // [RQ2]
      PORT_ONE_OFS:   next_rdata = pin_s2[15:8];
      PORT_TWO_OFS:   next_rdata = pin_s2[23:16];
      PORT_THREE_OFS: next_rdata = pin_s2[31:24];
      PORT_FOUR_OFS:  next_rdata = pin_s2[39:32];
      PORT_FIVE_OFS:  next_rdata = pin_s2[47:40];
      PORT_SIX_OFS:   next_rdata = pin_s2[55:48];
      PORT_SEVEN_OFS: next_rdata = sev_s2; // whole byte at once [RQ8]
      CONV_CTRL1_OFS: next_rdata = conv_ctrl1;
      PORT_EIGHT_OFS: next_rdata = {4'h0, eig_s2}; // [RQ10] [RQ8]
      default:        next_rdata = 8'h00; // unmapped reads zero
    endcase
  end

  // registered read data
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // external bus request bundle
  assign ext.addr_phase = ext_addr;
  assign ext.data_out   = ext_write;
  assign ext.wide_addr  = ext_wide;
  assign ext.addr_lo    = ext_a[7:0];
  assign ext.addr_hi    = ext_a[15:8];
  assign ext.wdata      = ext_wd;

  pio_pin_drv u_drv (
    .latch_zero (latch[0]),
    .latch_two  (latch[2]),
    .ext        (ext),
    .next_zero_o  (next_zero_o),
    .next_zero_oe (next_zero_oe),
    .next_two_o   (next_two_o)
  );

  // captured read byte from port zero buffers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_rdata <= 8'h00;
    end else if (ext_read) begin
      ext_rdata <= pin_s2[7:0]; // [RQ3]
    end
  end

  // pin drivers, registered
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      port_o  <= {NUM_PORTS{LATCH_RESET}};
      port_oe <= '0;
    end else begin
      port_o  <= {latch[6], latch[5], latch[4], latch[3], next_two_o,
                  latch[1], next_zero_o}; // [RQ1] [RQ4]
      port_oe <= {48'hffff_ffff_ffff, {8{next_zero_oe}}};
      if (ext_read && !ext_addr && !ext_write) begin
        port_oe[7:0] <= 8'h00; // release for read data [RQ3]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // assertions
  a_input_write_ignored: assert property ( // [RQ7]
    @(posedge mclk) disable iff (!rst_n)
    reg_wr && (reg_addr == PORT_SEVEN_OFS || reg_addr == PORT_EIGHT_OFS)
    |=> {latch[6], latch[5], latch[4], latch[3], latch[2], latch[1],
         latch[0], conv_ctrl1} == $past({latch[6], latch[5], latch[4],
         latch[3], latch[2], latch[1], latch[0], conv_ctrl1}))
    else $error("input port write changed state");
  a_eight_upper_zero: assert property ( // [RQ10]
    @(posedge mclk) disable iff (!rst_n)
    reg_rd && reg_addr == PORT_EIGHT_OFS |=> reg_rdata[7:4] == 4'h0)
    else $error("port eight upper bits not zero");
  a_latch_write_pin: assert property ( // [RQ2]
    @(posedge mclk) disable iff (!rst_n)
    reg_wr && reg_addr == PORT_ONE_OFS
    |=> ##1 port_o[15:8] == $past(reg_wdata, 2))
    else $error("port one latch not driven");
  a_wide_high_addr: assert property ( // [RQ4]
    @(posedge mclk) disable iff (!rst_n)
    ext_wide |=> port_o[23:16] == $past(ext_a[15:8]))
    else $error("high address not driven");
  a_low_addr_out: assert property ( // [RQ3]
    @(posedge mclk) disable iff (!rst_n)
    ext_addr |=> port_o[7:0] == $past(ext_a[7:0]) && &port_oe[7:0])
    else $error("low address not driven");
  a_chan_select: assert property ( // [RQ6]
    @(posedge mclk) disable iff (!rst_n)
    reg_wr && reg_addr == CONV_CTRL1_OFS
    |=> ##1 chan_sel == $past(reg_wdata[3:0], 2))
    else $error("channel select not applied");
  a_seven_reads_pins: assert property ( // [RQ5]
    @(posedge mclk) disable iff (!rst_n)
    reg_rd && reg_addr == PORT_SEVEN_OFS |=> reg_rdata == $past(sev_s2))
    else $error("port seven read wrong");
  a_two_keeps_latch: assert property ( // [RQ1]
    @(posedge mclk) disable iff (!rst_n)
    !ext_wide |=> port_o[23:16] == $past(latch[2]))
    else $error("port two lost latch value");
endmodule : pio_ports

// ### pio_far_side.sv
// far-side model: pin pull-ups and an external memory answering reads
`timescale 1ns/100ps
module pio_far_side (
  input  wire logic [55:0] port_o,  // pin values from the block
  input  wire logic [55:0] port_oe, // high while the block drives
  input  wire logic [7:0]  mem_rd,  // byte the memory returns
  output logic      [55:0] port_i   // resolved pin levels
);
  ////////////////////////////////////////////////////////////////////////////
  // released pins float high through pull-ups
  // port zero carries the memory byte while the block lets go of it
  always_comb begin
    port_i = port_o | ~port_oe;
    if (port_oe[7:0] == 8'h00) port_i[7:0] = mem_rd;
  end
endmodule : pio_far_side

// ### parallel_io_and_analog_input_ports_tb_top.sv
// testbench: register, pin and memory bus checks for the port block
`timescale 1ns/100ps
module parallel_io_and_analog_input_ports_tb_top;
  import pio_pkg::*;
  logic        mclk, rst_n, reg_wr, reg_rd;       // clock, reset, strobes
  logic        ext_addr, ext_write, ext_read;     // memory bus phases
  logic        ext_wide;                          // wide address
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;    // register bus
  logic [15:0] ext_a;                             // memory address
  logic [7:0]  ext_wd, ext_rdata, mem_rd;         // memory data
  logic [55:0] port_i, port_o, port_oe;           // bidirectional pins
  logic [7:0]  ain_seven_i;                       // input-only pins
  logic [3:0]  ain_eight_i, chan_sel;             // pins, channel select
  logic [7:0]  val [7];                           // latch values written
  logic [7:0]  ofs [7];                           // port offsets
  int          err_count, tests_run, cyc;         // report counters
  ////////////////////////////////////////////////////////////////////////////
  pio_ports u_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .ext_addr(ext_addr), .ext_write(ext_write),
    .ext_read(ext_read), .ext_wide(ext_wide), .ext_a(ext_a),
    .ext_wd(ext_wd), .ext_rdata(ext_rdata), .port_i(port_i),
    .port_o(port_o), .port_oe(port_oe), .ain_seven_i(ain_seven_i),
    .ain_eight_i(ain_eight_i), .chan_sel(chan_sel));
  pio_far_side u_far (.port_o(port_o), .port_oe(port_oe), .mem_rd(mem_rd),
    .port_i(port_i));
  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr
  // read strobe for one cycle, data checked a cycle later under a mask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp,
                    input logic [7:0] msk = 8'hff);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    chk(reg_rdata & msk, exp & msk);
  endtask : rc
  // whole pin vector against the latches, all driven
  task automatic pins;
    for (int i = 0; i < 7; i++) begin
      chk(port_o[8*i +: 8], val[i]);
      chk(port_oe[8*i +: 8], 8'hff);
    end
  endtask : pins
  task automatic results;
    if (err_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, reg_wr, reg_rd, ext_addr, ext_write, ext_read, ext_wide} = '0;
    {reg_addr, reg_wdata, ext_a, ext_wd, mem_rd} = '0;
    ain_seven_i = 8'ha5;
    ain_eight_i = 4'h9;
    ofs = '{PORT_ZERO_OFS, PORT_ONE_OFS, PORT_TWO_OFS, PORT_THREE_OFS,
            PORT_FOUR_OFS, PORT_FIVE_OFS, PORT_SIX_OFS};
    for (int i = 0; i < 7; i++) val[i] = 8'hff;
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    pins();
    for (int i = 0; i < 7; i++) rc(ofs[i], 8'hff);
    rc(CONV_CTRL1_OFS, 8'h00);
    // writes to every latch, one idle cycle between them
    for (int i = 0; i < 7; i++) val[i] = 8'(60 + 33 * i);
    for (int i = 0; i < 7; i++) wr(ofs[i], val[i]);
    repeat (4) @(negedge mclk);
    pins();
    for (int i = 0; i < 7; i++) rc(ofs[i], val[i]);
    // input-only ports: writes ignored, pins read whole
    wr(PORT_SEVEN_OFS, 8'h00);
    wr(PORT_EIGHT_OFS, 8'hff);
    wr(8'h81, 8'h77);
    repeat (3) @(negedge mclk);
    pins();
    rc(PORT_SEVEN_OFS, 8'ha5);
    rc(PORT_EIGHT_OFS, 8'h09);
    rc(8'h81, 8'h00);
    ain_seven_i = 8'h5a;
    ain_eight_i = 4'h6;
    repeat (3) @(negedge mclk);
    rc(PORT_SEVEN_OFS, 8'h5a);
    rc(PORT_EIGHT_OFS, 8'h06);
    // low nibble serves analog input, its digital value is masked off
    ain_seven_i = 8'h5c;
    repeat (3) @(negedge mclk);
    rc(PORT_SEVEN_OFS, 8'h50, 8'hf0);
    // channel select field
    wr(CONV_CTRL1_OFS, 8'hff);
    repeat (2) @(negedge mclk);
    chk({4'h0, chan_sel}, 8'h0f);
    rc(CONV_CTRL1_OFS, 8'h8f);
    wr(CONV_CTRL1_OFS, 8'h06);
    repeat (2) @(negedge mclk);
    chk({4'h0, chan_sel}, 8'h06);
    // memory access: address, write data, then read capture
    ext_a = 16'h1234;
    ext_wd = 8'h96;
    ext_addr = 1'b1;
    ext_wide = 1'b1;
    repeat (2) @(negedge mclk);
    chk(port_o[7:0], 8'h34);
    chk(port_o[23:16], 8'h12);
    ext_wide = 1'b0;
    repeat (2) @(negedge mclk);
    chk(port_o[23:16], val[2]);
    ext_addr = 1'b0;
    ext_write = 1'b1;
    repeat (2) @(negedge mclk);
    chk(port_o[7:0], 8'h96);
    chk(port_oe[7:0], 8'hff);
    ext_write = 1'b0;
    ext_read = 1'b1;
    mem_rd = 8'hc3;
    repeat (5) @(negedge mclk);
    chk(port_oe[7:0], 8'h00);
    chk(ext_rdata, 8'hc3);
    ext_read = 1'b0;
    results();
  end
endmodule : parallel_io_and_analog_input_ports_tb_top
